// *** common/psc_pkg.sv ***
package psc_pkg;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int MACRO_COUNT = 8;
    localparam int WAKE_COUNT = 9;
    localparam int PIN_COUNT = 32;
    localparam int MODULE_COUNT = 16;
    localparam int BROWNOUT_COUNT = 4;
    localparam int EVENT_COUNT = 6;

    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h08;
    localparam logic [7:0] ADDR_WAKE_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_RET_MACROS = 8'h10;
    localparam logic [7:0] ADDR_HIB_MACROS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_SECURITY = 8'h20;

    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // Control register fields.
    localparam int CTRL_REQ_LSB = 0;
    localparam int CTRL_CLKGATE_BIT = 3;
    localparam int CTRL_RADIO_SLEEP_BIT = 4;
    localparam int CTRL_CPU_IDLE_BIT = 5;

    // Wake source bit positions.
    localparam int WAKE_TIMER = 0;
    localparam int WAKE_GPIO = 1;
    localparam int WAKE_KEYBOARD = 2;
    localparam int WAKE_MOUSE = 3;
    localparam int WAKE_SENSOR = 4;
    localparam int WAKE_DEBUG = 5;
    localparam int WAKE_OFF_TIMER = 6;
    localparam int WAKE_DIGITAL_PIN = 7;
    localparam int WAKE_COMPARATOR = 8;

    // Interrupt event bit positions; the brownout lines follow EV_BROWNOUT_LSB.
    localparam int EV_WAKE = 0;
    localparam int EV_ENTERED = 1;
    localparam int EV_BROWNOUT_LSB = 2;

    localparam int SEC_FUSE_BIT = 0;
    localparam int SEC_OTP_LOCK_BIT = 1;

    localparam logic [7:0] RET_MACROS_RESET = 8'hFF;
    localparam logic [7:0] HIB_MACROS_RESET = 8'h00;
    localparam logic [7:0] RADIO_MACROS = 8'hC0;

    localparam real CLOCK_MHZ = 20.0;
    localparam real PWD_MIN_US = 100.0;
    localparam int PWD_MIN_CYCLES = int'($ceil(PWD_MIN_US * CLOCK_MHZ));

    typedef enum logic [2:0] {
        REQ_NONE, REQ_RETENTION, REQ_HIBERNATION, REQ_SOC_OFF
    } psc_req_type;

    typedef enum {
        ST_RESET, ST_ACTIVE, ST_RETENTION, ST_HIBERNATION, ST_SOC_OFF, ST_POWERDOWN
    } psc_state_type;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic write;
        logic read;
    } psc_bus_type;

    typedef struct packed {
        logic chip_reset;
        logic radio_off;
        logic core_off;
        logic memory_off;
        logic top_off;
        logic unit_off;
        logic clock_gate;
        logic cpu_idle;
    } psc_power_type;
endpackage

// *** verilog/psc_controller.sv ***
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Function
// - Hold chip reset until the power unit reports stable supplies.
// - No reset pin; the power-down pin acts as chip reset.
// - Software resets individual modules by writing a register.
// - Five primary power states with secondary sub-states.
// - Active powers all; clock gating, CPU idle, radio-only deep sleep.
// - Eight 16 KB macros, two for radio, selectable per low-power state; SoC Off powers all macros off.
// - Retention keeps flip-flops and selected SRAM in 16 kB steps.
// - Pins latch on entry to Retention or Hibernation and hold.
// - Retention wakes on timer, GPIO, keyboard, mouse, sensor, debug.
// - Hibernation powers off memory, keeps little state and pins.
// - SoC Off powers all digital off; return is a cold boot.
// - SoC Off wakes only on timer, wake pin, or comparator.
// - Low-power and medium-power clock domains with crystal or oscillator.
// - Brownout events raise interrupts to software.
// - Security fuse disables slave interfaces; separate OTP write lock.
module psc_controller
    import psc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire psc_bus_type bus,
    output logic [DATA_WIDTH-1:0] rdata,
    input wire logic supplies_stable,
    input wire logic power_down_pin,
    input wire logic low_clock_use_oscillator,
    input wire logic mid_clock_use_oscillator,
    input wire logic [WAKE_COUNT-1:0] wake_sources,
    input wire logic [BROWNOUT_COUNT-1:0] brownout,
    input wire logic [PIN_COUNT-1:0] pin_live,
    output logic [PIN_COUNT-1:0] pin_held,
    output logic pin_hold,
    output psc_power_type power,
    output logic [MACRO_COUNT-1:0] macro_powered,
    output logic [MODULE_COUNT-1:0] module_reset,
    output logic low_clock_select_oscillator,
    output logic mid_clock_select_oscillator,
    output logic slave_disable,
    output logic otp_write_block,
    output logic irq
);
    psc_state_type state;
    psc_state_type next_state;
    logic [7:0] control;
    logic [MODULE_COUNT-1:0] soft_reset;
    logic [WAKE_COUNT-1:0] wake_enable;
    logic [MACRO_COUNT-1:0] ret_macros;
    logic [MACRO_COUNT-1:0] hib_macros;
    logic [EVENT_COUNT-1:0] irq_status;
    logic [EVENT_COUNT-1:0] irq_mask;
    logic fuse;
    logic otp_lock;
    logic [11:0] pwd_count;
    logic pwd_long;

    wire write_control = bus.write && bus.addr == ADDR_CONTROL;
    wire [2:0] request = bus.wdata[CTRL_REQ_LSB +: 3];
    wire low_trigger = write_control && state == ST_ACTIVE && request != REQ_NONE;
    wire [WAKE_COUNT-1:0] wake_live = wake_sources & wake_enable;
    wire [WAKE_COUNT-1:0] ret_wake_set = (WAKE_COUNT)'(9'h03F);
    wire [WAKE_COUNT-1:0] off_wake_set = (WAKE_COUNT)'(9'h1C0);
    wire wake_ret = |(wake_live & ret_wake_set);
    wire wake_off = |(wake_live & off_wake_set);
    wire in_low = state == ST_RETENTION || state == ST_HIBERNATION || state == ST_SOC_OFF;
    wire wake_fire = (state == ST_RETENTION || state == ST_HIBERNATION) ? wake_ret :
                     (state == ST_SOC_OFF) ? wake_off : 1'b0;
    wire entered = state == ST_ACTIVE && next_state != ST_ACTIVE && next_state != ST_POWERDOWN;
    wire [EVENT_COUNT-1:0] events;
    assign events[EV_WAKE] = in_low && wake_fire;
    assign events[EV_ENTERED] = entered;
    assign events[EV_BROWNOUT_LSB +: BROWNOUT_COUNT] = brownout;
    wire [EVENT_COUNT-1:0] status_clear =
        (bus.write && bus.addr == ADDR_IRQ_STATUS) ? bus.wdata[EVENT_COUNT-1:0] : '0;

    // The power-down pin and a SoC Off wake are the only chip reset paths besides power-on reset.
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (supplies_stable && !power_down_pin) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (low_trigger) begin
                    case (request)
                        REQ_RETENTION: next_state = ST_RETENTION;
                        REQ_HIBERNATION: next_state = ST_HIBERNATION;
                        REQ_SOC_OFF: next_state = ST_SOC_OFF;
                        default: next_state = ST_ACTIVE;
                    endcase
                end
            end
            ST_RETENTION, ST_HIBERNATION: begin
                if (wake_fire) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_SOC_OFF: begin
                if (wake_fire) begin
                    next_state = ST_RESET;
                end
            end
            ST_POWERDOWN: begin
                if (!power_down_pin) begin
                    next_state = ST_RESET;
                end
            end
            default: next_state = ST_RESET;
        endcase
        if (pwd_long) begin
            next_state = ST_POWERDOWN;
        end else if (power_down_pin && state != ST_POWERDOWN) begin
            next_state = ST_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwd_count <= '0;
        end else if (!power_down_pin) begin
            pwd_count <= '0;
        end else if (!pwd_long) begin
            pwd_count <= pwd_count + 12'h001;
        end
    end
    assign pwd_long = pwd_count >= 12'(PWD_MIN_CYCLES);

    // Cold boot from SoC Off: control, soft reset, wake enable, macro and IRQ mask registers return to reset values.
    wire cold = reset || state == ST_RESET;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (cold) begin
            control <= 8'h00;
            soft_reset <= '0;
            wake_enable <= '0;
            ret_macros <= RET_MACROS_RESET;
            hib_macros <= HIB_MACROS_RESET;
            irq_mask <= '0;
        end else if (bus.write && state == ST_ACTIVE) begin
            case (bus.addr)
                ADDR_CONTROL: control <= bus.wdata[7:0];
                ADDR_SOFT_RESET: soft_reset <= bus.wdata[MODULE_COUNT-1:0];
                ADDR_WAKE_ENABLE: wake_enable <= bus.wdata[WAKE_COUNT-1:0];
                ADDR_RET_MACROS: ret_macros <= bus.wdata[MACRO_COUNT-1:0];
                ADDR_HIB_MACROS: hib_macros <= bus.wdata[MACRO_COUNT-1:0];
                ADDR_IRQ_MASK: irq_mask <= bus.wdata[EVENT_COUNT-1:0];
                default: control <= control;
            endcase
        end
    end

    // Fuses are one-way: once set they stay until power is removed.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fuse <= 1'b0;
            otp_lock <= 1'b0;
        end else if (bus.write && bus.addr == ADDR_SECURITY) begin
            fuse <= fuse | bus.wdata[SEC_FUSE_BIT];
            otp_lock <= otp_lock | bus.wdata[SEC_OTP_LOCK_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~status_clear) | events;
        end
    end
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_held <= '0;
            pin_hold <= 1'b0;
        end else if (entered && next_state != ST_SOC_OFF) begin
            pin_held <= pin_live;
            pin_hold <= 1'b1;
        end else if (state == ST_ACTIVE || state == ST_RESET) begin
            pin_hold <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            power <= '{chip_reset: 1'b1, default: 1'b0};
            macro_powered <= '1;
        end else begin
            power.chip_reset <= next_state == ST_RESET || next_state == ST_POWERDOWN;
            power.radio_off <= next_state != ST_ACTIVE || control[CTRL_RADIO_SLEEP_BIT];
            power.clock_gate <= next_state == ST_ACTIVE && control[CTRL_CLKGATE_BIT];
            power.cpu_idle <= next_state == ST_ACTIVE && control[CTRL_CPU_IDLE_BIT];
            power.core_off <= next_state == ST_HIBERNATION || next_state == ST_SOC_OFF
                || next_state == ST_POWERDOWN;
            power.memory_off <= next_state == ST_HIBERNATION || next_state == ST_SOC_OFF;
            power.top_off <= next_state == ST_SOC_OFF || next_state == ST_POWERDOWN;
            power.unit_off <= next_state == ST_POWERDOWN;
            case (next_state)
                ST_ACTIVE: macro_powered <= control[CTRL_RADIO_SLEEP_BIT] ? ~RADIO_MACROS : '1;
                ST_RETENTION: macro_powered <= ret_macros;
                ST_HIBERNATION: macro_powered <= hib_macros;
                default: macro_powered <= '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            module_reset <= '1;
            low_clock_select_oscillator <= 1'b0;
            mid_clock_select_oscillator <= 1'b0;
            slave_disable <= 1'b0;
            otp_write_block <= 1'b0;
        end else begin
            module_reset <= soft_reset | {MODULE_COUNT{power.chip_reset}};
            low_clock_select_oscillator <= low_clock_use_oscillator;
            mid_clock_select_oscillator <= mid_clock_use_oscillator;
            slave_disable <= fuse;
            otp_write_block <= otp_lock;
        end
    end

    wire [DATA_WIDTH-1:0] read_mux =
        bus.addr == ADDR_CONTROL ? DATA_WIDTH'(control) :
        bus.addr == ADDR_STATE ? DATA_WIDTH'(state) :
        bus.addr == ADDR_SOFT_RESET ? DATA_WIDTH'(soft_reset) :
        bus.addr == ADDR_WAKE_ENABLE ? DATA_WIDTH'(wake_enable) :
        bus.addr == ADDR_RET_MACROS ? DATA_WIDTH'(ret_macros) :
        bus.addr == ADDR_HIB_MACROS ? DATA_WIDTH'(hib_macros) :
        bus.addr == ADDR_IRQ_STATUS ? DATA_WIDTH'(irq_status) :
        bus.addr == ADDR_IRQ_MASK ? DATA_WIDTH'(irq_mask) :
        bus.addr == ADDR_SECURITY ? DATA_WIDTH'({otp_lock, fuse}) : READ_UNMAPPED;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (bus.read) begin
            rdata <= read_mux;
        end else begin
            rdata <= '0;
        end
    end

    a_reset_until_stable: assert property (@(posedge sys_clk) disable iff (reset)
        state == ST_RESET && !supplies_stable |=> power.chip_reset)
        else $error("Chip reset released before supplies were stable.");
    a_pin_resets_chip: assert property (@(posedge sys_clk) disable iff (reset)
        power_down_pin |=> state == ST_RESET || state == ST_POWERDOWN)
        else $error("Power-down pin did not reset the chip.");
    a_low_entry_active: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(state) && (state == ST_RETENTION || state == ST_HIBERNATION)
        |-> $past(state) == ST_ACTIVE)
        else $error("Low-power state entered from outside Active.");
    a_pin_hold_kept: assert property (@(posedge sys_clk) disable iff (reset)
        state == ST_RETENTION && $past(state) == ST_RETENTION |-> $stable(pin_held))
        else $error("Held pins changed during Retention.");
    a_retention_wake: assert property (@(posedge sys_clk) disable iff (reset)
        state == ST_RETENTION && wake_ret && !power_down_pin |=> state == ST_ACTIVE)
        else $error("Enabled Retention wake did not return to Active.");
    a_off_cold_boot: assert property (@(posedge sys_clk) disable iff (reset)
        state == ST_SOC_OFF && !power_down_pin && wake_off |=> state == ST_RESET)
        else $error("SoC Off wake did not cold boot.");
    // The power outputs are loaded from next_state, so they change on the same edge as state.
    a_powerdown_time: assert property (@(posedge sys_clk) disable iff (reset)
        pwd_long |=> state == ST_POWERDOWN && power.unit_off)
        else $error("Long power-down pin did not shut off the power unit.");
    a_retention_core_on: assert property (@(posedge sys_clk) disable iff (reset)
        state == ST_RETENTION |-> !power.core_off && !power.memory_off)
        else $error("Retention removed core or memory power.");
    a_fuse_sticky: assert property (@(posedge sys_clk) disable iff (reset)
        fuse |=> fuse ##1 slave_disable)
        else $error("Security fuse cleared or not applied.");
    a_brownout_irq: assert property (@(posedge sys_clk) disable iff (reset)
        brownout[0] |=> irq_status[EV_BROWNOUT_LSB])
        else $error("Brownout event not recorded.");
endmodule

// *** sim/psc_controller_tb.sv ***
`timescale 1ns/1ps
module psc_controller_tb;
    import psc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    psc_bus_type bus = '0;
    logic [DATA_WIDTH-1:0] rdata;
    logic supplies_stable = 1'b0;
    logic power_down_pin = 1'b0;
    logic low_osc = 1'b0;
    logic mid_osc = 1'b0;
    logic [WAKE_COUNT-1:0] wake_sources = '0;
    logic [BROWNOUT_COUNT-1:0] brownout = '0;
    logic [PIN_COUNT-1:0] pin_live = '0;
    logic [PIN_COUNT-1:0] pin_held;
    logic pin_hold;
    psc_power_type power;
    logic [MACRO_COUNT-1:0] macro_powered;
    logic [MODULE_COUNT-1:0] module_reset;
    logic low_sel, mid_sel, slave_disable, otp_write_block, irq;
    int fail_count = 0;
    int total_checks = 0;
    logic [15:0] lfsr_state = 16'h0052;
    logic [31:0] v, r, pins;
    int i;

    psc_controller psc_controller_i (.sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata),
        .supplies_stable(supplies_stable), .power_down_pin(power_down_pin),
        .low_clock_use_oscillator(low_osc), .mid_clock_use_oscillator(mid_osc),
        .wake_sources(wake_sources), .brownout(brownout), .pin_live(pin_live),
        .pin_held(pin_held), .pin_hold(pin_hold), .power(power), .macro_powered(macro_powered),
        .module_reset(module_reset), .low_clock_select_oscillator(low_sel),
        .mid_clock_select_oscillator(mid_sel), .slave_disable(slave_disable),
        .otp_write_block(otp_write_block), .irq(irq));

    always #25 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Off-state wake sources and Retention/Hibernation wake sources are disjoint sets.
    function automatic logic exp_wake(input int st, input int src);
        if (st == 4) begin
            return src >= WAKE_OFF_TIMER;
        end
        return src <= WAKE_DEBUG;
    endfunction

    task automatic rnd(output logic [31:0] x);
        lfsr_state = lfsr_step(lfsr_state);
        x[31:16] = lfsr_state;
        lfsr_state = lfsr_step(lfsr_state);
        x[15:0] = lfsr_state;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0000_0000, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_state(input logic [31:0] exp);
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            rd(ADDR_STATE, s);
            n++;
        end while (s !== exp && n < 20);
        chk("state", exp, s);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wake_with(input int src);
        @(posedge sys_clk);
        wake_sources <= 9'h001 << src;
        wait_state(32'h1);
        chk("pin_hold", 32'h0, pin_hold);
        @(posedge sys_clk);
        wake_sources <= '0;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        tick(5);
        chk("chip_reset", 32'h1, power.chip_reset);
        @(posedge sys_clk);
        supplies_stable <= 1'b1;
        wait_state(32'h1);
        chk("chip_reset", 32'h0, power.chip_reset);
        rd(ADDR_RET_MACROS, r);
        chk("ret_macros", 32'h0000_00FF, r);
        rd(ADDR_HIB_MACROS, r);
        chk("hib_macros", 32'h0000_0000, r);
        rd(8'hFC, r);
        chk("unmapped", READ_UNMAPPED, r);
        rnd(v);
        @(posedge sys_clk);
        low_osc <= v[0];
        mid_osc <= v[1];
        tick(2);
        chk("low_sel", v[0], low_sel);
        chk("mid_sel", v[1], mid_sel);
        wr(ADDR_SOFT_RESET, v);
        tick(1);
        chk("module_reset", v[15:0], module_reset);
        wr(ADDR_SOFT_RESET, 32'h0);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CONTROL, i << CTRL_CLKGATE_BIT);
            tick(1);
            chk("clock_gate", i[0], power.clock_gate);
            chk("radio_off", i[1], power.radio_off);
            chk("cpu_idle", i[2], power.cpu_idle);
            chk("macros", i[1] ? {24'h0, ~RADIO_MACROS} : 32'hFF, macro_powered);
        end
        wr(ADDR_CONTROL, 32'h0);
        $display("test reset and active done");
        for (i = 0; i < WAKE_COUNT; i++) begin
            rnd(v);
            rnd(pins);
            wr(ADDR_WAKE_ENABLE, 32'h1FF);
            wr(ADDR_RET_MACROS, v);
            pin_live <= pins;
            wr(ADDR_CONTROL, 32'h1);
            tick(1);
            chk("pin_hold", 32'h1, pin_hold);
            chk("macros", v[7:0], macro_powered);
            chk("radio_off", 32'h1, power.radio_off);
            chk("core_off", 32'h0, power.core_off);
            @(posedge sys_clk);
            pin_live <= ~pins;
            tick(2);
            chk("pin_held", pins, pin_held);
            @(posedge sys_clk);
            wake_sources <= 9'h001 << i;
            if (exp_wake(2, i)) begin
                wait_state(32'h1);
            end else begin
                tick(5);
                rd(ADDR_STATE, r);
                chk("state", 32'h2, r);
            end
            wake_with(WAKE_TIMER);
        end
        // A source that is not enabled must not end retention.
        wr(ADDR_WAKE_ENABLE, 32'h1FD);
        wr(ADDR_CONTROL, 32'h1);
        @(posedge sys_clk);
        wake_sources <= 9'h002;
        tick(5);
        rd(ADDR_STATE, r);
        chk("state", 32'h2, r);
        wake_with(WAKE_TIMER);
        $display("test retention done");
        rd(ADDR_IRQ_STATUS, r);
        chk("wake_status", 32'h3, r[1:0]);
        chk("irq", 32'h0, irq);
        wr(ADDR_IRQ_MASK, 32'h1);
        tick(1);
        chk("irq", 32'h1, irq);
        wr(ADDR_IRQ_STATUS, 32'h1);
        tick(1);
        chk("irq", 32'h0, irq);
        for (i = 0; i < BROWNOUT_COUNT; i++) begin
            @(posedge sys_clk);
            brownout <= 4'h1 << i;
            @(posedge sys_clk);
            brownout <= '0;
            rd(ADDR_IRQ_STATUS, r);
            chk("brownout_status", 32'h1, r[EV_BROWNOUT_LSB + i]);
            wr(ADDR_IRQ_MASK, 32'h1 << (EV_BROWNOUT_LSB + i));
            tick(1);
            chk("irq", 32'h1, irq);
            wr(ADDR_IRQ_STATUS, 32'h1 << (EV_BROWNOUT_LSB + i));
            tick(1);
            chk("irq", 32'h0, irq);
        end
        $display("test interrupts done");
        rnd(v);
        wr(ADDR_HIB_MACROS, v);
        wr(ADDR_CONTROL, 32'h2);
        tick(1);
        chk("memory_off", 32'h1, power.memory_off);
        chk("core_off", 32'h1, power.core_off);
        chk("pin_hold", 32'h1, pin_hold);
        chk("macros", v[7:0], macro_powered);
        wr(ADDR_CONTROL, 32'h3);
        rd(ADDR_STATE, r);
        chk("state", 32'h3, r);
        wake_with(WAKE_DEBUG);
        wr(ADDR_RET_MACROS, 32'h3C);
        wr(ADDR_CONTROL, 32'h3);
        tick(1);
        chk("top_off", 32'h1, power.top_off);
        @(posedge sys_clk);
        wake_sources <= 9'h03F;
        tick(5);
        rd(ADDR_STATE, r);
        chk("state", 32'h4, r);
        @(posedge sys_clk);
        wake_sources <= '0;
        wake_with(WAKE_OFF_TIMER + int'(v[9:8] % 3));
        rd(ADDR_RET_MACROS, r);
        chk("ret_macros", 32'hFF, r);
        $display("test low power done");
        @(posedge sys_clk);
        power_down_pin <= 1'b1;
        tick(2);
        chk("chip_reset", 32'h1, power.chip_reset);
        tick(PWD_MIN_CYCLES - 20);
        chk("unit_off", 32'h0, power.unit_off);
        tick(30);
        chk("unit_off", 32'h1, power.unit_off);
        @(posedge sys_clk);
        power_down_pin <= 1'b0;
        wait_state(32'h1);
        $display("test power down done");
        // Fuse last: it may shut the register port for good.
        wr(ADDR_SECURITY, 32'h2);
        tick(1);
        chk("otp_block", 32'h1, otp_write_block);
        chk("slave_off", 32'h0, slave_disable);
        wr(ADDR_SECURITY, 32'h1);
        wr(ADDR_SECURITY, 32'h0);
        tick(1);
        chk("slave_off", 32'h1, slave_disable);
        chk("otp_block", 32'h1, otp_write_block);
        $display("test security done");
        final_report;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report;
    end
endmodule
